// *** rtl/clock_gen_pkg.sv ***
// Purpose: Shared constants for the processor phase clock generator.
// Assumes: A 100 MHz system clock stands in for the divided oscillator.
// Notes:   All timing counts derive from printed times and the clock period.
package clock_gen_pkg;

    // Timing.
    localparam int CLK_PERIOD_NS   = 10;
    localparam int OSC_FREQ_KHZ    = 44400;
    localparam int OSC_DIVIDE      = 4;
    localparam int BASIC_PERIOD_NS = 90;
    localparam int MICROCYCLE_NS   = 270;
    localparam int RING_STAGES     = MICROCYCLE_NS / BASIC_PERIOD_NS;

    localparam logic [3:0] BASIC_CYCLES =
        4'((BASIC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] BASIC_LAST   = 4'(BASIC_CYCLES - 4'h1);
    localparam logic [3:0] BASIC_HIGH   = 4'(BASIC_CYCLES / 4'h2);
    localparam logic [2:0] RING_RESET   = 3'h1;

    // Positions of the external inputs in the synchroniser vector.
    localparam int IN_RUN   = 0;
    localparam int IN_WHOLE = 1;
    localparam int IN_SEQ   = 2;
    localparam int IN_MW    = 3;
    localparam int IN_REFR  = 4;
    localparam int IN_PAR   = 5;
    localparam int IN_MREQ  = 6;
    localparam int IN_GRANT = 7;
    localparam int IN_DISP  = 8;
    localparam int IN_PFEN  = 9;
    localparam int IN_PFNV  = 10;
    localparam int IN_BUSY  = 11;
    localparam int IN_DREQ  = 12;
    localparam int IN_COUNT = 13;

    // Phase two gate and step request bit positions.
    localparam int G_DP  = 0;
    localparam int G_SEQ = 1;
    localparam int G_MW  = 2;

    // Register map.
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_MASK   = 8'h04;
    localparam logic [7:0] REG_STATE  = 8'h08;

    localparam int         STATUS_W      = 2;
    localparam int         ST_PARITY     = 0;
    localparam int         ST_STEP_DONE  = 1;
    localparam logic [1:0] MASK_RESET    = 2'h0;
    localparam logic [1:0] STATUS_RESET  = 2'h0;

    // Layout of the state register.
    localparam int SF_RING = 0;
    localparam int SF_STEP = 3;
    localparam int SF_REFR = 6;
    localparam int SF_STALL = 7;
    localparam int SF_RUN  = 8;

endpackage : clock_gen_pkg

// *** rtl/input_sync.sv ***
// Purpose: Two-stage synchroniser with a rising edge detector per bit.
// Assumes: Inputs are asynchronous levels.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module input_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Raw and conditioned levels.
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] last;
    } sync_st_t;

    sync_st_t s_q;
    sync_st_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.meta = async_in;
        s_d.sync = s_q.meta;
        s_d.last = s_q.sync;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level = s_q.sync;
    assign rise  = s_q.sync & ~s_q.last;

endmodule : input_sync

// *** rtl/phase_clock_gen.sv ***
// Purpose: Basic clock divider, three-phase ring and gated phase two clocks.
// Assumes: Console and memory controller signals are asynchronous levels.
// Notes:   Phase two gating is decided only when the ring enters phase two.
//
// Notes on behaviour
// - Divide down to continuous 90 ns basic clock.
// - Three-stage ring makes phases zero, one, two.
// - Phases zero and one always run freely.
// - Phase two has three separately gated outputs.
// - Run high runs phase two; low stops it.
// - Whole step pulses all three phase two outputs.
// - Sequencer step pulses sequencer clock only.
// - Microword step pulses microword load clock only.
// - Refresh suppresses phase two for one microcycle.
// - Parity error stalls while present, raises interrupt.
// - Ungranted memory request stalls until grant.
// - Dispatch waiting on prefetch stalls while busy.
// - Data request stalls while memory busy.
// - Refresh also delays stepping by one microcycle.
// - Stepping stalls block only the datapath clock.
`timescale 1ns/1ps
module phase_clock_gen
    import clock_gen_pkg::*;
(
    // Clock and reset.
    input  wire logic        MCLK,
    input  wire logic        RST_B,
    // Console control.
    input  wire logic        RUN_ENABLE,
    input  wire logic        WHOLE_PROCESSOR_STEP,
    input  wire logic        SEQUENCER_STEP_REQUEST,
    input  wire logic        MICROWORD_STEP_REQUEST,
    // Stall sources.
    input  wire logic        STORE_REFRESH_REQUEST,
    input  wire logic        STORE_PARITY_ERROR,
    input  wire logic        MEMORY_REQUEST,
    input  wire logic        MEMORY_GRANT,
    input  wire logic        DISPATCH_MICROOP_ACTIVE,
    input  wire logic        PREFETCH_WAIT_ENABLE,
    input  wire logic        PREFETCH_NOT_VALID,
    input  wire logic        MEMORY_BUSY,
    input  wire logic        DATA_REQUEST,
    // Clock outputs.
    output logic             BASIC_CLOCK,
    output logic             FIRST_RING_PHASE,
    output logic             SECOND_RING_PHASE,
    output logic             DATAPATH_PHASE_CLOCK,
    output logic             SEQUENCER_COUNTER_PHASE_CLOCK,
    output logic             MICROWORD_LOAD_CLOCK,
    output logic             CLOCK_STALL,
    output logic             IRQ,
    // APB slave.
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR
);

    typedef struct packed {
        logic [3:0]          div;
        logic                basic;
        logic [2:0]          ring;
        logic [2:0]          gate;
        logic [2:0]          step_pend;
        logic                refr_pend;
        logic                ph0;
        logic                ph1;
        logic                dp;
        logic                seq;
        logic                mw;
        logic                stall;
        logic [STATUS_W-1:0] status;
        logic [STATUS_W-1:0] mask;
        logic [31:0]         prdata;
        logic                pslverr;
        logic                pready;
        logic                irq;
    } gen_st_t;

    function automatic logic reg_hit(input logic [7:0] addr);
        reg_hit = (addr == REG_STATUS) || (addr == REG_MASK) || (addr == REG_STATE);
    endfunction : reg_hit

    ////////////////////////////////////////////////////////////////////////////////
    // Input conditioning.

    logic [IN_COUNT-1:0] raw_in;
    logic [IN_COUNT-1:0] lvl;
    logic [IN_COUNT-1:0] rise;

    always_comb begin
        raw_in           = '0;
        raw_in[IN_RUN]   = RUN_ENABLE;
        raw_in[IN_WHOLE] = WHOLE_PROCESSOR_STEP;
        raw_in[IN_SEQ]   = SEQUENCER_STEP_REQUEST;
        raw_in[IN_MW]    = MICROWORD_STEP_REQUEST;
        raw_in[IN_REFR]  = STORE_REFRESH_REQUEST;
        raw_in[IN_PAR]   = STORE_PARITY_ERROR;
        raw_in[IN_MREQ]  = MEMORY_REQUEST;
        raw_in[IN_GRANT] = MEMORY_GRANT;
        raw_in[IN_DISP]  = DISPATCH_MICROOP_ACTIVE;
        raw_in[IN_PFEN]  = PREFETCH_WAIT_ENABLE;
        raw_in[IN_PFNV]  = PREFETCH_NOT_VALID;
        raw_in[IN_BUSY]  = MEMORY_BUSY;
        raw_in[IN_DREQ]  = DATA_REQUEST;
    end

    input_sync #(
        .WIDTH    (IN_COUNT)
    ) u_sync (
        .clk      (MCLK),
        .rst_b    (RST_B),
        .async_in (raw_in),
        .level    (lvl),
        .rise     (rise)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Stall and decision terms.

    gen_st_t s_q;
    gen_st_t s_d;

    logic       basic_tick;
    logic       decide;
    logic       stall_now;
    logic       run;
    logic       apb_setup;
    logic       apb_write;
    logic [2:0] steps;

    // The stall output is level-true, so memory handshakes release it promptly.
    always_comb begin
        stall_now = lvl[IN_PAR]
                  | (lvl[IN_MREQ] & ~lvl[IN_GRANT])
                  | (lvl[IN_DISP] & ~lvl[IN_MREQ] & lvl[IN_PFEN]
                     & lvl[IN_PFNV] & lvl[IN_BUSY])
                  | (lvl[IN_DREQ] & lvl[IN_BUSY]);
    end

    assign basic_tick = (s_q.div == BASIC_LAST);
    assign decide     = basic_tick && s_q.ring[1];
    assign run        = lvl[IN_RUN];
    assign apb_setup  = PSEL && !PENABLE;
    assign apb_write  = PSEL && PENABLE && s_q.pready && PWRITE;
    assign steps      = {rise[IN_MW], rise[IN_SEQ], rise[IN_WHOLE]};

    ////////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        s_d = s_q;

        // Basic clock divider runs unconditionally.
        s_d.div   = basic_tick ? 4'h0 : 4'(s_q.div + 4'h1);
        s_d.basic = (s_d.div < BASIC_HIGH);

        // Ring counter advances once per basic period.
        if (basic_tick) begin
            s_d.ring = {s_q.ring[1:0], s_q.ring[2]};
        end

        // A new edge survives a consume in the same cycle.
        s_d.step_pend = s_q.step_pend | steps;
        s_d.refr_pend = s_q.refr_pend | rise[IN_REFR];

        if (basic_tick && s_q.ring[2]) begin
            s_d.gate = 3'h0;
        end

        if (decide) begin
            s_d.gate      = 3'h0;
            s_d.refr_pend = rise[IN_REFR];
            if (s_q.refr_pend) begin
                // Refresh takes this whole microcycle, steps wait.
                s_d.gate      = 3'h0;
                s_d.step_pend = s_q.step_pend | steps;
            end else if (run) begin
                s_d.gate      = stall_now ? 3'h0 : 3'h7;
                // Steps while running are not meaningful and are dropped.
                s_d.step_pend = steps;
            end else begin
                s_d.gate[G_DP]  = s_q.step_pend[G_DP] & ~stall_now;
                s_d.gate[G_SEQ] = s_q.step_pend[G_DP] | s_q.step_pend[G_SEQ];
                s_d.gate[G_MW]  = s_q.step_pend[G_DP] | s_q.step_pend[G_MW];
                s_d.step_pend   = steps;
            end
        end

        // Registered clock outputs, phase two gated by the latched decision.
        s_d.ph0   = s_d.ring[0];
        s_d.ph1   = s_d.ring[1];
        s_d.dp    = s_d.ring[2] & s_d.gate[G_DP];
        s_d.seq   = s_d.ring[2] & s_d.gate[G_SEQ];
        s_d.mw    = s_d.ring[2] & s_d.gate[G_MW];
        s_d.stall = stall_now;

        // Sticky events; a set in the clearing cycle wins.
        if (apb_write && PADDR == REG_STATUS) begin
            s_d.status = s_q.status & ~PWDATA[STATUS_W-1:0];
        end
        if (rise[IN_PAR]) begin
            s_d.status[ST_PARITY] = 1'b1;
        end
        if (decide && !s_q.refr_pend && !run && (s_q.step_pend != 3'h0)) begin
            s_d.status[ST_STEP_DONE] = 1'b1;
        end
        if (apb_write && PADDR == REG_MASK) begin
            s_d.mask = PWDATA[STATUS_W-1:0];
        end
        s_d.irq = |(s_d.status & s_d.mask);

        // Zero-wait slave: read data is captured in the setup cycle.
        s_d.pready = 1'b1;
        if (apb_setup) begin
            s_d.prdata  = 32'h0;
            s_d.pslverr = !reg_hit(PADDR);
            if (!PWRITE) begin
                unique case (PADDR)
                    REG_STATUS: s_d.prdata[STATUS_W-1:0] = s_q.status;
                    REG_MASK:   s_d.prdata[STATUS_W-1:0] = s_q.mask;
                    REG_STATE: begin
                        s_d.prdata[SF_RING +: 3] = s_q.ring;
                        s_d.prdata[SF_STEP +: 3] = s_q.step_pend;
                        s_d.prdata[SF_REFR]      = s_q.refr_pend;
                        s_d.prdata[SF_STALL]     = s_q.stall;
                        s_d.prdata[SF_RUN]       = run;
                    end
                    default:    s_d.prdata = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            s_q        <= '0;
            s_q.ring   <= RING_RESET;
            s_q.ph0    <= 1'b1;
            s_q.basic  <= 1'b1;
            s_q.mask   <= MASK_RESET;
            s_q.status <= STATUS_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign BASIC_CLOCK                   = s_q.basic;
    assign FIRST_RING_PHASE              = s_q.ph0;
    assign SECOND_RING_PHASE             = s_q.ph1;
    assign DATAPATH_PHASE_CLOCK          = s_q.dp;
    assign SEQUENCER_COUNTER_PHASE_CLOCK = s_q.seq;
    assign MICROWORD_LOAD_CLOCK          = s_q.mw;
    assign CLOCK_STALL                   = s_q.stall;
    assign IRQ                           = s_q.irq;
    assign PRDATA                        = s_q.prdata;
    assign PREADY                        = s_q.pready;
    assign PSLVERR                       = s_q.pslverr;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    AST_BASIC_PERIOD: assert property (@(posedge MCLK) disable iff (!RST_B)
        basic_tick |=> !basic_tick [*8] ##1 basic_tick)
        else $error("Basic period is not nine cycles.");

    AST_RING_ONEHOT: assert property (@(posedge MCLK) disable iff (!RST_B)
        $onehot(s_q.ring) and (basic_tick && s_q.ring[2] |=> s_q.ring[0]))
        else $error("Ring counter is not a rotating one-hot.");

    AST_PHASE0_FREE: assert property (@(posedge MCLK) disable iff (!RST_B)
        basic_tick && s_q.ring[2] |=> FIRST_RING_PHASE ##9 SECOND_RING_PHASE)
        else $error("Free-running phases failed to advance.");

    AST_P2_IN_PHASE2: assert property (@(posedge MCLK) disable iff (!RST_B)
        (DATAPATH_PHASE_CLOCK || SEQUENCER_COUNTER_PHASE_CLOCK || MICROWORD_LOAD_CLOCK)
        |-> s_q.ring[2] && !FIRST_RING_PHASE && !SECOND_RING_PHASE)
        else $error("Phase two clock outside phase two.");

    AST_RUN_FULL: assert property (@(posedge MCLK) disable iff (!RST_B)
        decide && run && !s_q.refr_pend && !stall_now
        |=> (DATAPATH_PHASE_CLOCK && SEQUENCER_COUNTER_PHASE_CLOCK && MICROWORD_LOAD_CLOCK) [*8]
        ##1 (DATAPATH_PHASE_CLOCK && SEQUENCER_COUNTER_PHASE_CLOCK && MICROWORD_LOAD_CLOCK))
        else $error("Running phase two clocks missing or short.");

    AST_STOPPED: assert property (@(posedge MCLK) disable iff (!RST_B)
        decide && !run && s_q.step_pend == 3'h0 |=> s_q.gate == 3'h0)
        else $error("Phase two ran while stopped without a step.");

    AST_SEQ_STEP: assert property (@(posedge MCLK) disable iff (!RST_B)
        decide && !run && !s_q.refr_pend && s_q.step_pend == 3'h2
        |=> SEQUENCER_COUNTER_PHASE_CLOCK && !DATAPATH_PHASE_CLOCK && !MICROWORD_LOAD_CLOCK)
        else $error("Sequencer step drove the wrong clocks.");

    AST_MW_STEP: assert property (@(posedge MCLK) disable iff (!RST_B)
        decide && !run && !s_q.refr_pend && s_q.step_pend == 3'h4
        |=> MICROWORD_LOAD_CLOCK && !DATAPATH_PHASE_CLOCK && !SEQUENCER_COUNTER_PHASE_CLOCK)
        else $error("Microword step drove the wrong clocks.");

    AST_STEP_STALL: assert property (@(posedge MCLK) disable iff (!RST_B)
        decide && !run && !s_q.refr_pend && s_q.step_pend[G_DP] && stall_now
        |=> !DATAPATH_PHASE_CLOCK && SEQUENCER_COUNTER_PHASE_CLOCK && MICROWORD_LOAD_CLOCK)
        else $error("Stall during stepping blocked the wrong clocks.");

    AST_REFRESH: assert property (@(posedge MCLK) disable iff (!RST_B)
        decide && s_q.refr_pend |=> (s_q.gate == 3'h0) [*8])
        else $error("Refresh did not suppress phase two.");

    AST_PARITY: assert property (@(posedge MCLK) disable iff (!RST_B)
        rise[IN_PAR] |=> CLOCK_STALL && s_q.status[ST_PARITY])
        else $error("Parity error did not stall and flag.");

    AST_GRANT: assert property (@(posedge MCLK) disable iff (!RST_B)
        lvl[IN_MREQ] && !lvl[IN_GRANT] |=> CLOCK_STALL)
        else $error("Ungranted memory request did not stall.");

    AST_WHOLE_STEP: assert property (@(posedge MCLK) disable iff (!RST_B)
        decide && !run && !s_q.refr_pend && s_q.step_pend[G_DP] && !stall_now
        |=> DATAPATH_PHASE_CLOCK && SEQUENCER_COUNTER_PHASE_CLOCK && MICROWORD_LOAD_CLOCK)
        else $error("Whole step did not pulse all phase two clocks.");

    AST_REFR_STEP_WAIT: assert property (@(posedge MCLK) disable iff (!RST_B)
        decide && s_q.refr_pend && !run && s_q.step_pend != 3'h0
        |=> s_q.gate == 3'h0 && s_q.step_pend != 3'h0)
        else $error("Refresh did not hold back a pending step.");

    AST_RUN_STALL: assert property (@(posedge MCLK) disable iff (!RST_B)
        decide && run && stall_now |=> s_q.gate == 3'h0)
        else $error("Phase two ran during a stall.");

    AST_PREFETCH: assert property (@(posedge MCLK) disable iff (!RST_B)
        lvl[IN_DISP] && !lvl[IN_MREQ] && lvl[IN_PFEN] && lvl[IN_PFNV] && lvl[IN_BUSY]
        |=> CLOCK_STALL)
        else $error("Prefetch wait did not stall.");

    AST_DATA_BUSY: assert property (@(posedge MCLK) disable iff (!RST_B)
        lvl[IN_DREQ] && lvl[IN_BUSY] |=> CLOCK_STALL)
        else $error("Busy data transfer did not stall.");

    AST_GATE_STEADY: assert property (@(posedge MCLK) disable iff (!RST_B)
        !decide && !(basic_tick && s_q.ring[2]) |=> s_q.gate == $past(s_q.gate))
        else $error("Phase two gating changed off the decision edge.");

endmodule : phase_clock_gen

// *** verification/mem_ctrl_model.sv ***
// Purpose: Memory controller seen from the clock generator: grant and busy.
// Assumes: Requests are levels held by the bench until answered.
// Notes:   Wait length and hard error are chosen by the bench.
`timescale 1ns/1ps
module mem_ctrl_model (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Requests.
    input  wire logic       mem_req,
    input  wire logic       xfer_req,
    // Behaviour chosen by the bench.
    input  wire logic [7:0] wait_cycles,
    input  wire logic       hard_error,
    // Answers.
    output logic            grant,
    output logic            busy
);
    logic [7:0] wait_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_q <= 8'h00;
        end else if ((mem_req | xfer_req) && wait_q != 8'hff) begin
            wait_q <= wait_q + 8'h01;
        end else if (!(mem_req | xfer_req)) begin
            wait_q <= 8'h00;
        end
    end

    // A controller busy elsewhere grants only after the chosen delay.
    assign grant = mem_req && (wait_q >= wait_cycles);
    // A hard error ends busy at once so the processor is never held forever.
    assign busy = xfer_req && (wait_q < wait_cycles) && !hard_error;
endmodule : mem_ctrl_model

// *** verification/phase_clock_gen_tb.sv ***
// Purpose: Self-checking bench for the phase clock generator.
// Assumes: The memory controller is the behavioural model beside it.
// Notes:   Phase two pulses are counted by rising edge, widths on every fall.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fails++; \
    $display("Error %s expected %0h seen %0h", nm, ex, got); end end

module phase_clock_gen_tb
    import clock_gen_pkg::*;
;
    localparam int LIMIT = 10000;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic        run = 1'b0;
    logic [2:0]  step_req = 3'h0;
    logic        refr = 1'b0;
    logic        par = 1'b0;
    logic        hard = 1'b0;
    logic [7:0]  wt = 8'h00;
    logic        mreq = 1'b0, disp = 1'b0, pfen = 1'b0, pfnv = 1'b0, dreq = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        grant, busy, basic, ph0, ph1, stall, irq, pready, pslverr, err;
    wire  [2:0]  ph2;
    logic [2:0]  prev = 3'h0;
    int          fails = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          lat0, lat1;
    int          rises[3] = '{0, 0, 0};
    int          width[3] = '{0, 0, 0};
    int          got[3];

    always #5 mclk = ~mclk;

    phase_clock_gen phase_clock_gen_inst (
        .MCLK(mclk), .RST_B(rst_b), .RUN_ENABLE(run),
        .WHOLE_PROCESSOR_STEP(step_req[0]), .SEQUENCER_STEP_REQUEST(step_req[1]),
        .MICROWORD_STEP_REQUEST(step_req[2]), .STORE_REFRESH_REQUEST(refr),
        .STORE_PARITY_ERROR(par), .MEMORY_REQUEST(mreq), .MEMORY_GRANT(grant),
        .DISPATCH_MICROOP_ACTIVE(disp), .PREFETCH_WAIT_ENABLE(pfen),
        .PREFETCH_NOT_VALID(pfnv), .MEMORY_BUSY(busy), .DATA_REQUEST(dreq),
        .BASIC_CLOCK(basic), .FIRST_RING_PHASE(ph0), .SECOND_RING_PHASE(ph1),
        .DATAPATH_PHASE_CLOCK(ph2[G_DP]), .SEQUENCER_COUNTER_PHASE_CLOCK(ph2[G_SEQ]),
        .MICROWORD_LOAD_CLOCK(ph2[G_MW]), .CLOCK_STALL(stall), .IRQ(irq),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

    mem_ctrl_model mem_ctrl_model_inst (
        .clk(mclk), .rst_b(rst_b), .mem_req(mreq), .xfer_req(dreq | (disp & pfnv)),
        .wait_cycles(wt), .hard_error(hard), .grant(grant), .busy(busy));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        if (fails == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done

    always @(posedge mclk) begin
        cyc++;
        for (int i = 0; i < 3; i++) begin
            if (ph2[i] === 1'b1 && prev[i] === 1'b0) rises[i] <= rises[i] + 1;
            if (ph2[i] === 1'b0 && prev[i] === 1'b1) `CHK("p2 width", 9, width[i])
            width[i] = (ph2[i] === 1'b1) ? width[i] + 1 : 0;
        end
        prev = ph2;
        if (cyc == LIMIT) begin
            fails++;
            test_done();
        end
    end

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb

    task automatic window(input int n);
        int s[3];
        s = rises;
        repeat (n) @(posedge mclk);
        foreach (got[i]) got[i] = rises[i] - s[i];
    endtask : window

    task automatic chk3(input string nm, input int d, input int q, input int m);
        `CHK(nm, d, got[G_DP])
        `CHK(nm, q, got[G_SEQ])
        `CHK(nm, m, got[G_MW])
    endtask : chk3

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_apb();
        apb(REG_MASK, 1'b0, 32'h0);
        `CHK("mask reset", 32'h0, rd)
        apb(8'h0c, 1'b0, 32'h0);
        `CHK("unmapped err", 1'b1, err)
        apb(REG_MASK, 1'b1, 32'h3);
        apb(REG_MASK, 1'b0, 32'h0);
        `CHK("mask rw", 32'h3, rd)
        apb(REG_STATE, 1'b0, 32'h0);
        `CHK("state run", 1'b0, rd[SF_RUN])
    endtask : t_apb

    task automatic t_free();
        int hb, h0, h1, both;
        hb = 0;
        h0 = 0;
        h1 = 0;
        both = 0;
        repeat (270) begin
            @(posedge mclk);
            hb += int'(basic === 1'b1);
            h0 += int'(ph0 === 1'b1);
            h1 += int'(ph1 === 1'b1);
            both += int'(ph0 === 1'b1 && ph1 === 1'b1);
        end
        `CHK("basic high", 120, hb)
        `CHK("phase0 high", 90, h0)
        `CHK("phase1 high", 90, h1)
        `CHK("overlap", 0, both)
    endtask : t_free

    task automatic t_run();
        run <= 1'b1;
        repeat (40) @(posedge mclk);
        window(162);
        chk3("running", 6, 6, 6);
        repeat (6) begin
            repeat (13) @(posedge mclk);
            run <= ~run;
        end
        @(posedge mclk);
        run <= 1'b0;
        repeat (40) @(posedge mclk);
        window(162);
        chk3("stopped", 0, 0, 0);
    endtask : t_run

    task automatic t_steps();
        for (int k = 0; k < 3; k++) begin
            step_req[k] <= 1'b1;
            window(60);
            chk3("step", int'(k == 0), int'(k != 2), int'(k != 1));
            `CHK("step irq", 1'b1, irq)
            step_req[k] <= 1'b0;
            apb(REG_STATUS, 1'b1, 32'h2);
        end
        apb(REG_STATUS, 1'b0, 32'h0);
        `CHK("status clear", 32'h0, rd)
    endtask : t_steps

    task automatic step_latency(input logic with_refr, output int lat);
        do @(posedge mclk); while (ph1 !== 1'b0);
        do @(posedge mclk); while (ph1 !== 1'b1);
        step_req[0] <= 1'b1;
        refr <= with_refr;
        lat = 0;
        while (ph2[G_DP] !== 1'b1) begin
            @(posedge mclk);
            lat++;
        end
        step_req[0] <= 1'b0;
        refr <= 1'b0;
        repeat (30) @(posedge mclk);
    endtask : step_latency

    task automatic t_refresh();
        run <= 1'b1;
        repeat (40) @(posedge mclk);
        refr <= 1'b1;
        window(162);
        chk3("refresh", 5, 5, 5);
        refr <= 1'b0;
        run <= 1'b0;
        repeat (40) @(posedge mclk);
        step_latency(1'b0, lat0);
        step_latency(1'b1, lat1);
        `CHK("refresh step delay", 27, lat1 - lat0)
    endtask : t_refresh

    task automatic t_parity();
        apb(REG_MASK, 1'b1, 32'h1);
        run <= 1'b1;
        par <= 1'b1;
        repeat (10) @(posedge mclk);
        `CHK("parity stall", 1'b1, stall)
        `CHK("parity irq", 1'b1, irq)
        window(81);
        chk3("parity hold", 0, 0, 0);
        run <= 1'b0;
        repeat (5) @(posedge mclk);
        step_req[0] <= 1'b1;
        window(60);
        chk3("step in stall", 0, 1, 1);
        step_req[0] <= 1'b0;
        par <= 1'b0;
        repeat (5) @(posedge mclk);
        `CHK("stall gone", 1'b0, stall)
        apb(REG_STATUS, 1'b1, 32'h3);
        `CHK("irq cleared", 1'b0, irq)
    endtask : t_parity

    task automatic mem_case(input logic [4:0] c, input int w, input int hard_at, input logic e);
        wt <= 8'(w);
        {mreq, disp, pfen, pfnv, dreq} <= c;
        repeat (10) @(posedge mclk);
        `CHK("mem stall", e, stall)
        repeat (hard_at - 10) @(posedge mclk);
        hard <= 1'b1;
        repeat (15) @(posedge mclk);
        `CHK("mem release", 1'b0, stall)
        {mreq, disp, pfen, pfnv, dreq} <= 5'h00;
        hard <= 1'b0;
        repeat (5) @(posedge mclk);
    endtask : mem_case

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (2) @(posedge mclk);
        t_apb();
        t_free();
        t_run();
        t_steps();
        t_refresh();
        t_parity();
        mem_case(5'b10000, 40, 50, 1'b1);
        mem_case(5'b01110, 40, 50, 1'b1);
        mem_case(5'b01010, 40, 50, 1'b0);
        mem_case(5'b00001, 200, 30, 1'b1);
        test_done();
    end
endmodule : phase_clock_gen_tb
